// >>> mgl_consts.vh
`ifndef MGL_CONSTS_VH
`define MGL_CONSTS_VH

// Clock figures
`define MGL_OSC_PERIOD_NS 100
`define MGL_CPU_DIV 2
`define MGL_WAIT_EXT_NS 250
`define MGL_ROW_STROBE_CLKS 2

// Address bus layout
`define MGL_AD_W 16
`define MGL_AREA_BIT 15
`define MGL_BYTE_BIT 0
`define MGL_ROM_LO 1
`define MGL_ROM_HI 11
`define MGL_ROM_W 11
`define MGL_PAIR_LO 12
`define MGL_PAIR_HI 14
`define MGL_PAIRS 8
`define MGL_ROW_LO 1
`define MGL_ROW_HI 7
`define MGL_COL_LO 8
`define MGL_COL_HI 14
`define MGL_DRAM_AW 7

// Buffered control lines, bit order of the strobe vector
`define MGL_CTL_N 6
`define MGL_CTL_AS 0
`define MGL_CTL_DS 1
`define MGL_CTL_MEM_REQUEST 2
`define MGL_CTL_RW 3
`define MGL_CTL_NS 4
`define MGL_CTL_BW 5

// Reset values
`define MGL_AD_RST 16'h0000
`define MGL_CTL_RST 6'h3f
`define MGL_PAIR_RST 8'hff
`define MGL_DRAM_A_RST 7'h00
`define MGL_ROM_A_RST 11'h000

`endif

// >>> mgl_strobe_seq.v
`timescale 1ns/100ps
`default_nettype none
`include "mgl_consts.vh"

module mgl_strobe_seq
(
   // Clock and reset
   input wire clk_i,
   input wire reset_i,
   // Step on every falling processor clock edge
   input wire fall_tick_i,
   input wire addr_strobe_act_i,
   // Sequencer flip-flops, both idle high
   output reg row_strobe_ff_o,
   output reg delay_ff_o
);

   // Two-flop sequence stepped on the inverted processor clock
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         row_strobe_ff_o <= 1'b1;
         delay_ff_o <= 1'b1;
      end
      else if (fall_tick_i)
      begin
         case ({row_strobe_ff_o, delay_ff_o})
            2'b11:
            begin
               // Idle: a cycle starts while the address strobe is low
               row_strobe_ff_o <= ~addr_strobe_act_i;
            end
            2'b01:
            begin
               delay_ff_o <= 1'b0;
            end
            2'b00:
            begin
               row_strobe_ff_o <= 1'b1;
            end
            default:
            begin
               // Last step: restart at once if a new cycle is pending
               delay_ff_o <= 1'b1;
               row_strobe_ff_o <= ~addr_strobe_act_i;
            end
         endcase
      end
   end

endmodule // mgl_strobe_seq
`default_nettype wire

// >>> mgl_glue.v
// Contract
// - Processor clock is the oscillator divided by two for even duty.
// - Buffered control strobes float while bus grant acknowledge is low.
// - Bus grant acknowledge low also disables address latches and transceivers.
// - Address latched transparently while address strobe is low, held after.
// - Latched top address bit low selects ROM, high selects RAM.
// - ROM pairs addressed by latched bits 1 to 11; bit 0 ignored.
// - One-of-eight decoder picks the ROM pair inside the ROM area.
// - Wait asserted while ROM area selected and delay flop high.
// - Latched bits 1 to 14 multiplexed onto seven RAM address lines.
// - Row/column select is memory request taken on rising clock edge.
// - Row strobe is two-clock low pulse starting on falling edge.
// - Two idle-high flops step row and delay through fixed sequence.
// - Column strobe is RAM area AND row/column select AND read-or-data.
// - Read column strobe asserts once select follows memory request.
// - Write column strobe waits for data strobe, stretched by a flop.
// - Column strobe goes to both banks; byte write drops other bank.
`timescale 1ns/100ps
`default_nettype none
`include "mgl_consts.vh"

module mgl_glue
(
   // Oscillator clock and system reset
   input wire clk_i,
   input wire reset_i,
   // Processor clock output
   output reg cpu_clk_o,
   // Processor control outputs, active low unless named otherwise
   input wire addr_strobe_n_i,
   input wire data_strobe_n_i,
   input wire mem_request_n_i,
   input wire read_write_n_i,
   input wire normal_system_mode_i,
   input wire byte_word_sel_i,
   input wire bus_grant_ack_i,
   // Processor multiplexed address/data bus
   input wire [`MGL_AD_W-1:0] cpu_ad_i,
   output reg [`MGL_AD_W-1:0] cpu_ad_o,
   output reg cpu_ad_oe_o,
   // Processor wait input, active low
   output reg wait_n_o,
   // Buffered control strobes with output enable
   output reg [`MGL_CTL_N-1:0] buf_ctl_o,
   output reg [`MGL_CTL_N-1:0] buf_ctl_oe_o,
   // Latched address bus
   output reg [`MGL_AD_W-1:0] latched_addr_o,
   output reg latched_addr_oe_o,
   // Memory side data bus
   input wire [`MGL_AD_W-1:0] mem_data_i,
   output reg [`MGL_AD_W-1:0] mem_data_o,
   output reg mem_data_oe_o,
   // ROM array
   output reg [`MGL_ROM_W-1:0] rom_addr_o,
   output reg [`MGL_PAIRS-1:0] rom_pair_sel_n_o,
   // Dynamic RAM array
   output reg [`MGL_DRAM_AW-1:0] dram_addr_o,
   output wire row_strobe_n_o,
   output reg col_strobe_hi_n_o,
   output reg col_strobe_lo_n_o
);

   // Processor clock state and edge ticks
   wire fall_tick;
   wire rise_tick;
   // Active-high views of the processor strobes
   wire as_act;
   wire ds_act;
   wire mem_request_act;
   wire rd_cycle;
   // Address latch and its decoded views
   reg [`MGL_AD_W-1:0] latch_reg;
   wire [`MGL_AD_W-1:0] latch_view;
   wire ram_area;
   wire word_access;
   // Strobe timing
   reg row_col_select_reg;
   reg ds_stretch_reg;
   wire delay_ff;
   wire col_active;
   wire write_term;
   // Control strobes gathered in vector order
   wire [`MGL_CTL_N-1:0] ctl_raw;

   // One-of-eight decode, active low, with a common enable
   function [`MGL_PAIRS-1:0] dec_one_of_eight;
      input [2:0] sel;
      input en;
      begin
         dec_one_of_eight = `MGL_PAIR_RST;
         if (en)
         begin
            dec_one_of_eight[sel] = 1'b0;
         end
      end
   endfunction

   // Area decode from the latched top bit, shared by ROM and RAM paths
   function is_ram_area;
      input [`MGL_AD_W-1:0] addr;
      begin
         is_ram_area = addr[`MGL_AREA_BIT];
      end
   endfunction

   // Polarity helpers
   assign as_act = ~addr_strobe_n_i;
   assign ds_act = ~data_strobe_n_i;
   assign mem_request_act = ~mem_request_n_i;
   assign rd_cycle = read_write_n_i;
   assign word_access = byte_word_sel_i;
   assign ram_area = is_ram_area(latch_view);

   // The processor clock toggles on every rising oscillator edge, so the
   // oscillator cycle in which it is high is the one before its fall
   assign fall_tick = cpu_clk_o;
   assign rise_tick = ~cpu_clk_o;

   // Divide the oscillator by a toggle flop for an even duty cycle
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cpu_clk_o <= 1'b0;
      end
      else
      begin
         cpu_clk_o <= ~cpu_clk_o;
      end
   end

   // Transparent address latch: follows the bus while the address
   // strobe is low and holds once it rises; the falling edge alone
   // is never used to sample because the address is not yet valid
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         latch_reg <= `MGL_AD_RST;
      end
      else if (as_act)
      begin
         latch_reg <= cpu_ad_i;
      end
   end

   // Latch output: the bus itself while the strobe is low, as a
   // transparent latch shows it, so no decode sees a stale address
   assign latch_view = as_act ? cpu_ad_i : latch_reg;

   // Latched address output, released when the bus is granted away
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         latched_addr_o <= `MGL_AD_RST;
         latched_addr_oe_o <= 1'b0;
      end
      else
      begin
         latched_addr_o <= latch_view;
         latched_addr_oe_o <= bus_grant_ack_i;
      end
   end

   // Control strobes in the order of the buffered vector
   assign ctl_raw[`MGL_CTL_AS] = addr_strobe_n_i;
   assign ctl_raw[`MGL_CTL_DS] = data_strobe_n_i;
   assign ctl_raw[`MGL_CTL_MEM_REQUEST] = mem_request_n_i;
   assign ctl_raw[`MGL_CTL_RW] = read_write_n_i;
   assign ctl_raw[`MGL_CTL_NS] = normal_system_mode_i;
   assign ctl_raw[`MGL_CTL_BW] = byte_word_sel_i;

   // One three-state buffer per control line
   genvar gi;
   generate
      for (gi = 0; gi < `MGL_CTL_N; gi = gi + 1)
      begin : g_ctl_buf
         always @(posedge clk_i or posedge reset_i)
         begin
            if (reset_i)
            begin
               buf_ctl_o[gi] <= 1'b1;
               buf_ctl_oe_o[gi] <= 1'b0;
            end
            else
            begin
               buf_ctl_o[gi] <= ctl_raw[gi];
               buf_ctl_oe_o[gi] <= bus_grant_ack_i;
            end
         end
      end
   endgenerate

   // Data transceivers: toward the processor on reads while the data
   // strobe is low, toward memory during writes, off otherwise
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cpu_ad_o <= `MGL_AD_RST;
         cpu_ad_oe_o <= 1'b0;
         mem_data_o <= `MGL_AD_RST;
         mem_data_oe_o <= 1'b0;
      end
      else
      begin
         cpu_ad_o <= mem_data_i;
         mem_data_o <= cpu_ad_i;
         cpu_ad_oe_o <= bus_grant_ack_i & rd_cycle & ds_act;
         mem_data_oe_o <= bus_grant_ack_i & ~rd_cycle & mem_request_act;
      end
   end

   // ROM pair address and pair select inside the lower area
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rom_addr_o <= `MGL_ROM_A_RST;
         rom_pair_sel_n_o <= `MGL_PAIR_RST;
      end
      else
      begin
         // Bit 0 is dropped: ROM reads are always full words
         rom_addr_o <= latch_view[`MGL_ROM_HI:`MGL_ROM_LO];
         rom_pair_sel_n_o <=
            dec_one_of_eight(latch_view[`MGL_PAIR_HI:`MGL_PAIR_LO],
                             ~ram_area & mem_request_act);
      end
   end

   // Row strobe and delay flops on the inverted processor clock
   mgl_strobe_seq u_seq
   (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .fall_tick_i(fall_tick),
      .addr_strobe_act_i(as_act),
      .row_strobe_ff_o(row_strobe_n_o),
      .delay_ff_o(delay_ff)
   );

   // One wait state on each ROM access while the delay flop is high
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wait_n_o <= 1'b1;
      end
      else
      begin
         wait_n_o <= ~(~ram_area & delay_ff);
      end
   end

   // Memory request taken on the rising processor clock edge
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         row_col_select_reg <= 1'b0;
      end
      else if (rise_tick)
      begin
         row_col_select_reg <= mem_request_act;
      end
   end

   // Row half first, column half once the select has switched
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         dram_addr_o <= `MGL_DRAM_A_RST;
      end
      else if (row_col_select_reg)
      begin
         dram_addr_o <= latch_view[`MGL_COL_HI:`MGL_COL_LO];
      end
      else
      begin
         dram_addr_o <= latch_view[`MGL_ROW_HI:`MGL_ROW_LO];
      end
   end

   // Data strobe held over one falling edge to widen write strobes
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ds_stretch_reg <= 1'b0;
      end
      else if (fall_tick)
      begin
         ds_stretch_reg <= ds_act;
      end
   end

   // Writes wait for valid data; reads go as soon as select switches
   assign write_term = ds_act | ds_stretch_reg;
   assign col_active = ram_area & row_col_select_reg &
                       (rd_cycle | write_term);

   // Steer the column strobe to the byte banks; even byte is high bank
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         col_strobe_hi_n_o <= 1'b1;
         col_strobe_lo_n_o <= 1'b1;
      end
      else
      begin
         col_strobe_hi_n_o <= ~(col_active &
            (rd_cycle | word_access | ~latch_view[`MGL_BYTE_BIT]));
         col_strobe_lo_n_o <= ~(col_active &
            (rd_cycle | word_access | latch_view[`MGL_BYTE_BIT]));
      end
   end

endmodule // mgl_glue
`default_nettype wire

// >>> mgl_glue_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "mgl_consts.vh"

module mgl_glue_monitor
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Processor side
   input wire logic cpu_clk_o,
   input wire logic addr_strobe_n_i,
   input wire logic data_strobe_n_i,
   input wire logic read_write_n_i,
   input wire logic bus_grant_ack_i,
   input wire logic cpu_ad_oe_o,
   input wire logic wait_n_o,
   // Buffers and memory side
   input wire logic [`MGL_CTL_N-1:0] buf_ctl_oe_o,
   input wire logic latched_addr_oe_o,
   input wire logic [`MGL_AD_W-1:0] latched_addr_o,
   input wire logic [`MGL_PAIRS-1:0] rom_pair_sel_n_o,
   input wire logic row_strobe_n_o,
   input wire logic col_strobe_hi_n_o,
   input wire logic col_strobe_lo_n_o
);
   // One clock domain for every check
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   // Clock, buffer release and wait request
   a_clk_halves: assert property (!$past(reset_i) |->
      cpu_clk_o != $past(cpu_clk_o)) else $error("cpu clock not halved");
   a_ctl_oe_grant: assert property (!$past(reset_i) |->
      buf_ctl_oe_o == {`MGL_CTL_N{$past(bus_grant_ack_i)}})
      else $error("control buffers ignore grant");
   a_latch_oe_grant: assert property (!$past(reset_i) |->
      latched_addr_oe_o == $past(bus_grant_ack_i))
      else $error("address latch ignores grant");
   a_ram_no_wait: assert property (
      latched_addr_o[15] && $past(latched_addr_o[15]) |-> wait_n_o)
      else $error("wait raised in ram area");

   // Row strobe start and width
   a_row_on_fall: assert property ($fell(row_strobe_n_o) |->
      !$past(addr_strobe_n_i) && $past(cpu_clk_o))
      else $error("row strobe began off the falling edge");
   a_row_width: assert property ($fell(row_strobe_n_o) |->
      !row_strobe_n_o [*4] ##1 row_strobe_n_o)
      else $error("row strobe width wrong");

   // Column strobe, bank steering, rom select, transceiver
   a_col_ram_only: assert property (
      !(col_strobe_hi_n_o && col_strobe_lo_n_o) |-> latched_addr_o[15])
      else $error("column strobe outside ram");
   a_byte_bank: assert property (
      col_strobe_hi_n_o != col_strobe_lo_n_o |->
      latched_addr_o[0] == col_strobe_hi_n_o)
      else $error("byte bank steering wrong");
   a_rom_sel_area: assert property (rom_pair_sel_n_o != 8'hff |->
      $onehot(~rom_pair_sel_n_o) && !latched_addr_o[15])
      else $error("rom pair select wrong");
   a_read_xcvr: assert property (cpu_ad_oe_o |->
      $past(read_write_n_i) && !$past(data_strobe_n_i)
      && $past(bus_grant_ack_i)) else $error("read transceiver misdriven");

   // Main scenarios reached
   c_row: cover property ($fell(row_strobe_n_o));
   c_wait: cover property (!wait_n_o && !data_strobe_n_i);
   c_odd: cover property (col_strobe_hi_n_o && !col_strobe_lo_n_o);
endmodule // mgl_glue_monitor
`default_nettype wire

// >>> mgl_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

module mgl_cpu_model
(
   // Clocks and answers
   input wire logic clk_i,
   input wire logic cpu_clk_i,
   input wire logic wait_n_i,
   input wire logic [15:0] rdata_i,
   // Bus cycle outputs
   output logic as_n_o,
   output logic ds_n_o,
   output logic mem_request_n_o,
   output logic rw_o,
   output logic bw_o,
   output logic [15:0] ad_o
);
   // Idle: strobes high, word read
   initial
   begin
      {as_n_o, ds_n_o, mem_request_n_o, rw_o, bw_o} = 5'h1f;
      ad_o = 16'h0000;
   end

   // One oscillator period, settled after the edge
   task half;
      @(posedge clk_i);
      #10;
   endtask

   // T1, T2, up to four wait states while wait is low, then T3
   task cycle(input logic rd, input logic bw, input logic [15:0] a,
      input logic [15:0] wd, output logic [15:0] q, output int tw);
      logic w;
      tw = 0;
      half;
      while (cpu_clk_i !== 1'b1)
         half;
      as_n_o = 1'b0;
      mem_request_n_o = 1'b0;
      rw_o = rd;
      bw_o = bw;
      ad_o = a;
      half;
      half;
      as_n_o = 1'b1;
      ds_n_o = 1'b0;
      ad_o = rd ? ~a : wd; // Released lines never hold the address
      w = wait_n_i;
      while (w === 1'b0 && tw < 4)
      begin
         half;
         half;
         tw++;
         w = wait_n_i;
      end
      half;
      half;
      half;
      q = rdata_i;
      ds_n_o = 1'b1;
      mem_request_n_o = 1'b1;
      ad_o = ~ad_o;
   endtask
endmodule // mgl_cpu_model
`default_nettype wire

// >>> mgl_glue_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "mgl_consts.vh"

module mgl_glue_bench;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic grant = 1'b1;
   logic ns = 1'b1;
   logic row_idle;
   int n_mismatch = 0;
   int checks = 0;
   // Processor refresh period in processor clocks, set up by software
   localparam int REFRESH_CLKS = 60;
   int tw;
   logic [1:0] seen;
   logic [7:0] sel_seen;
   logic [15:0] q, wd_seen, rom_seen;
   logic [6:0] col_a;
   logic [6:0] row_a;
   wire as_n, ds_n, mem_request_n, rw, bw, cpu_clk, ad_oe, wait_n, row_n;
   wire la_oe, md_oe, hi_n, lo_n;
   wire [15:0] ad, cpu_ad, la, md;
   wire [5:0] ctl, ctl_oe;
   wire [10:0] rom_a;
   wire [7:0] sel_n;
   wire [6:0] dram_a;
   wire [15:0] rbus = ad_oe ? cpu_ad : ~ad;
   wire [15:0] mem = la ^ 16'h5a3c;

   always #50 clk_i = ~clk_i;

   mgl_glue i_dut (.clk_i(clk_i), .reset_i(reset_i), .cpu_clk_o(cpu_clk),
      .addr_strobe_n_i(as_n), .data_strobe_n_i(ds_n),
      .mem_request_n_i(mem_request_n), .read_write_n_i(rw),
      .normal_system_mode_i(ns), .byte_word_sel_i(bw),
      .bus_grant_ack_i(grant), .cpu_ad_i(ad), .cpu_ad_o(cpu_ad),
      .cpu_ad_oe_o(ad_oe), .wait_n_o(wait_n), .buf_ctl_o(ctl),
      .buf_ctl_oe_o(ctl_oe), .latched_addr_o(la), .latched_addr_oe_o(la_oe),
      .mem_data_i(mem), .mem_data_o(md), .mem_data_oe_o(md_oe),
      .rom_addr_o(rom_a), .rom_pair_sel_n_o(sel_n), .dram_addr_o(dram_a),
      .row_strobe_n_o(row_n), .col_strobe_hi_n_o(hi_n),
      .col_strobe_lo_n_o(lo_n));

   mgl_cpu_model i_cpu (.clk_i(clk_i), .cpu_clk_i(cpu_clk),
      .wait_n_i(wait_n), .rdata_i(rbus), .as_n_o(as_n), .ds_n_o(ds_n),
      .mem_request_n_o(mem_request_n), .rw_o(rw), .bw_o(bw), .ad_o(ad));

   // Record strobes, selects and write data of a cycle
   always @(posedge clk_i)
   begin
      seen <= seen | {~hi_n, ~lo_n};
      sel_seen <= sel_seen & sel_n;
      if (!(hi_n && lo_n))
         col_a <= dram_a;
      if (!row_n && hi_n && lo_n)
         row_a <= dram_a;
      if (sel_n != 8'hff)
         rom_seen <= {5'h00, rom_a};
      if (md_oe)
         wd_seen <= md;
   end

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Let stretched strobes end, then run one cycle
   task run(input logic r, input logic b, input logic [15:0] a, w);
      repeat (4) @(posedge clk_i);
      #10;
      seen = 2'b00;
      sel_seen = 8'hff;
      i_cpu.cycle(r, b, a, w, q, tw);
   endtask

   task t_reset;
      repeat (16) @(posedge clk_i);
      #10;
      chk({row_n, wait_n, ctl}, 16'h00ff);
      chk({sel_n, ctl_oe, la_oe, md_oe}, 16'hff00);
      reset_i = 1'b0;
      $display("reset done");
   endtask

   task t_rom;
      logic [15:0] a;
      logic [7:0] m;
      for (int p = 0; p < 8; p++)
      begin
         a = {1'b0, p[2:0], 8'h00, p[2:0], 1'b0} | 16'h0002;
         m = ~(8'h01 << p);
         run(1'b1, 1'b1, a, 16'h0000);
         chk(q, a ^ 16'h5a3c);
         chk(tw[15:0], 16'h0001);
         chk(sel_seen, m);
         chk(rom_seen, a[11:1]);
      end
      $display("rom reads done");
   endtask

   task t_ram_rd;
      logic [15:0] a;
      for (int k = 0; k < 3; k++)
      begin
         a = k == 0 ? 16'h8000 : k == 1 ? 16'hfffe : 16'hb5a6;
         run(1'b1, 1'b1, a, 16'h0000);
         chk(q, a ^ 16'h5a3c);
         chk(tw[15:0], 16'h0000);
         chk(seen, 2'b11);
         chk(col_a, a[14:8]);
         chk(row_a, a[7:1]);
      end
      $display("ram reads done");
   endtask

   task t_ram_wr;
      logic [15:0] a, w;
      for (int k = 0; k < 3; k++)
      begin
         a = k == 2 ? 16'hc3a1 : 16'hc3a0;
         w = 16'h1234 + k[15:0];
         run(1'b0, k == 0, a, w);
         chk(wd_seen, w);
         chk(seen, k == 0 ? 2'b11 : k == 1 ? 2'b10 : 2'b01);
      end
      $display("ram writes done");
   endtask

   task t_grant;
      @(posedge clk_i);
      #10;
      ns = 1'b0;
      grant = 1'b0;
      repeat (2) @(posedge clk_i);
      #10;
      chk({ctl_oe, la_oe, ad_oe, md_oe}, 16'h0000);
      chk(ctl, 16'h0007);
      grant = 1'b1;
      repeat (2) @(posedge clk_i);
      #10;
      chk(ctl_oe, 6'h3f);
      // Idle for two refresh periods: no row strobe of its own
      row_idle = 1'b1;
      repeat (4 * REFRESH_CLKS)
      begin
         @(posedge clk_i);
         #10;
         row_idle = row_idle & row_n;
      end
      chk(row_idle, 1'b1);
      $display("grant release done");
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      t_reset;
      t_rom;
      t_ram_rd;
      t_ram_wr;
      t_grant;
      end_of_test;
   end

   // Watchdog, far beyond the expected run
   initial
   begin
      #2000000;
      n_mismatch++;
      end_of_test;
   end
endmodule // mgl_glue_bench

bind mgl_glue mgl_glue_monitor i_mon (.clk_i, .reset_i, .cpu_clk_o,
   .addr_strobe_n_i, .data_strobe_n_i, .read_write_n_i, .bus_grant_ack_i,
   .cpu_ad_oe_o, .wait_n_o, .buf_ctl_oe_o, .latched_addr_oe_o,
   .latched_addr_o, .rom_pair_sel_n_o, .row_strobe_n_o,
   .col_strobe_hi_n_o, .col_strobe_lo_n_o);
`default_nettype wire
